//--- atcs_dev.sv
// Chosen here: the serial register port.
`timescale 1ns/1ps
`default_nettype none
`include "atcs_cfg.svh"

module atcs_dev
    import atcs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int RES_W = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Link to the host
    atcs_if.dev lnk,
    // Observed state
    output logic [2:0] mux_ch,
    output logic conv_busy,
    output logic fifo_on,
    output logic [RES_W-1:0] last_result
);

    localparam int PW = $clog2(FIFO_DEPTH);

    // Mode helpers, reserved codes fall to idle
    function automatic logic is_manual(input logic [2:0] m);
        return (m == ATCS_MAN) || (m == ATCS_MAN_DLY);
    endfunction : is_manual

    function automatic logic is_delay(input logic [2:0] m);
        return (m == ATCS_MAN_DLY) || (m == ATCS_AUTO_DLY);
    endfunction : is_delay

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] sys_r; // System configuration
    logic [7:0] intc_r; // Interrupt configuration
    logic [7:0] trig_r; // Trigger mode configuration
    logic [2:0] chsel_r; // Manual or starting channel
    logic [7:0] ccr_r [4]; // Per-group channel setup
    logic [2:0] mode; // Live mode field
    logic [2:0] mode_q_r; // Mode of previous cycle

    // Serial front end
    logic sclk_q_r;
    logic cs_q_r;
    logic [15:0] rx_r;
    logic [15:0] tx_r;
    logic [4:0] nbits_r;
    logic sclk_rise;
    logic cs_fall;
    logic frame_done;
    logic wr_en;
    logic cmd_read;
    logic cmd_scan;
    logic cmd_stop;
    logic conversion_start_pin_q_r;
    logic pin_start;

    // Conversion sequencer
    atcs_cstate_t st_r;
    logic [7:0] cnt_r;
    logic [2:0] scan_ch_r;
    logic [2:0] samp_ch_r;
    logic [7:0] seq_r;
    logic start_now;
    logic conv_end;

    // Result FIFO
    logic [RES_W-1:0] mem_r [FIFO_DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_f_r;
    logic fifo_full;
    logic fifo_pop;
    logic [RES_W-1:0] new_res;
    logic int_r;

    assign mode = trig_r[2:0];
    assign fifo_on = sys_r[`ATCS_SYS_FIFO];
    assign conv_busy = (st_r == CS_CONV);
    assign lnk.miso = tx_r[15];
    assign lnk.int_out = int_r;

    ////////////////////////////////////////////////////////////////////////
    // Frame decoding, same clock as the host so no synchroniser
    assign sclk_rise = lnk.sclk & ~sclk_q_r & ~lnk.cs_n;
    assign cs_fall = ~lnk.cs_n & cs_q_r;
    assign frame_done = lnk.cs_n & ~cs_q_r & (nbits_r == `ATCS_FRM_BITS);
    assign wr_en = frame_done & ~rx_r[`ATCS_FRM_CMD];
    assign cmd_read = frame_done & rx_r[`ATCS_FRM_CMD] & (rx_r[14:8] == `ATCS_OP_READ);
    assign cmd_scan = frame_done & rx_r[`ATCS_FRM_CMD] & (rx_r[14:8] == `ATCS_OP_SCAN);
    assign cmd_stop = frame_done & rx_r[`ATCS_FRM_CMD] & (rx_r[14:8] == `ATCS_OP_STOP);
    assign pin_start = ~lnk.conversion_start_pin_n & conversion_start_pin_q_r;
    assign fifo_full = (cnt_f_r == (PW+1)'(FIFO_DEPTH));
    assign fifo_pop = cs_fall & fifo_on & (cnt_f_r != '0);

    // Edge history of link pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
            conversion_start_pin_q_r <= 1'b1;
        end else if (ce) begin
            sclk_q_r <= lnk.sclk;
            cs_q_r <= lnk.cs_n;
            conversion_start_pin_q_r <= lnk.conversion_start_pin_n;
        end
    end

    // Shift registers, reply loaded as the frame opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_r <= 16'h0000;
            tx_r <= 16'h0000;
            nbits_r <= 5'h00;
        end else if (ce) begin
            if (cs_fall) begin
                nbits_r <= 5'h00;
                // Left aligned; FIFO head when enabled, else latest result
                tx_r <= {(fifo_on ? ((cnt_f_r != '0) ? mem_r[rp_r] : '0) : last_result), 4'h0};
            end else if (sclk_rise) begin
                rx_r <= {rx_r[14:0], lnk.mosi};
                tx_r <= {tx_r[14:0], 1'b0};
                nbits_r <= nbits_r + 5'h01;
            end
        end
    end

    // Register writes; short frames are dropped whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_r <= `ATCS_REG_RST;
            intc_r <= `ATCS_REG_RST;
            trig_r <= `ATCS_REG_RST;
            chsel_r <= `ATCS_CH_RST;
            for (int i = 0; i < 4; i++) begin
                ccr_r[i] <= `ATCS_REG_RST;
            end
        end else if (ce && wr_en) begin
            unique case (rx_r[14:8])
                `ATCS_ADDR_SYS: sys_r <= rx_r[7:0];
                `ATCS_ADDR_INT: intc_r <= rx_r[7:0];
                `ATCS_ADDR_TRIG: trig_r <= rx_r[7:0];
                `ATCS_ADDR_CHSEL: chsel_r <= rx_r[2:0];
                default: begin
                    // Channel group setup occupies the lowest four addresses
                    if (rx_r[14:10] == 5'h00) begin
                        ccr_r[rx_r[9:8]] <= rx_r[7:0];
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    always_comb begin
        start_now = 1'b0;
        if (st_r == CS_IDLE) begin
            if (is_manual(mode)) begin
                start_now = pin_start | (cmd_read & sys_r[`ATCS_SYS_SWSTART]);
            end else if (mode == ATCS_AUTO_DLY) begin
                start_now = pin_start;
            end
        end
    end
    assign conv_end = (st_r == CS_CONV) && (cnt_r == 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= CS_IDLE;
            cnt_r <= 8'h00;
            scan_ch_r <= `ATCS_CH_RST;
            mode_q_r <= 3'h0;
        end else if (ce) begin
            mode_q_r <= mode;
            if (mode != mode_q_r) begin
                // Mode change aborts; mode four waits out the set-up window
                st_r <= (mode == ATCS_AUTO_DLY) ? CS_GAP : CS_IDLE;
                cnt_r <= 8'(`ATCS_M4_WIN_CYC);
            end else if ((mode == ATCS_SCAN1 || mode == ATCS_SCANN) && cmd_scan) begin
                st_r <= CS_ACQ;
                cnt_r <= `ATCS_ACQ_CYC;
                scan_ch_r <= chsel_r;
            end else if (mode == ATCS_SCANN && cmd_stop) begin
                st_r <= CS_IDLE;
            end else begin
                unique case (st_r)
                    CS_IDLE: begin
                        if (start_now) begin
                            st_r <= CS_ACQ;
                            cnt_r <= `ATCS_ACQ_CYC;
                        end
                    end
                    CS_ACQ: begin
                        cnt_r <= cnt_r - 8'h01;
                        if (cnt_r == 8'h01) begin
                            st_r <= CS_CONV;
                            cnt_r <= `ATCS_CONV_CYC;
                        end
                    end
                    CS_CONV: begin
                        cnt_r <= cnt_r - 8'h01;
                        if (conv_end) begin
                            cnt_r <= `ATCS_AUTO_GAP;
                            if (mode == ATCS_AUTO_DLY) begin
                                st_r <= CS_GAP;
                            end else if (mode == ATCS_SCANN) begin
                                st_r <= CS_GAP;
                                scan_ch_r <= (scan_ch_r == `ATCS_LAST_CH) ? chsel_r : scan_ch_r + 3'h1;
                            end else if (mode == ATCS_SCAN1 && scan_ch_r != `ATCS_LAST_CH) begin
                                st_r <= CS_GAP;
                                scan_ch_r <= scan_ch_r + 3'h1;
                            end else begin
                                st_r <= CS_IDLE;
                            end
                        end
                    end
                    CS_GAP: begin
                        cnt_r <= cnt_r - 8'h01;
                        if (cnt_r == 8'h01 || pin_start) begin
                            st_r <= CS_ACQ;
                            cnt_r <= `ATCS_ACQ_CYC;
                        end
                    end
                endcase
            end
        end
    end

    // Multiplexer: direct in mode two, late switch in delay modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_ch <= `ATCS_CH_RST;
            samp_ch_r <= `ATCS_CH_RST;
        end else if (ce) begin
            if (st_r == CS_ACQ && cnt_r == 8'h01) begin
                samp_ch_r <= mux_ch;
                if (is_delay(mode)) begin
                    // Next channel settles during conversion, not acquisition
                    mux_ch <= chsel_r;
                end
            end else if (mode == ATCS_MAN) begin
                mux_ch <= chsel_r;
            end else if (mode == ATCS_SCAN1 || mode == ATCS_SCANN) begin
                mux_ch <= scan_ch_r;
            end else if (is_delay(mode) && mode_q_r != mode) begin
                mux_ch <= chsel_r;
            end
        end
    end

    // Result word: channel tag plus running sequence number
    assign new_res = RES_W'({samp_ch_r, 1'b0, seq_r});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_r <= 8'h00;
            last_result <= '0;
        end else if (ce && conv_end) begin
            seq_r <= seq_r + 8'h01;
            last_result <= new_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result FIFO; when full the oldest entry is lost, never the newest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_f_r <= '0;
        end else if (ce) begin
            if (!fifo_on || (mode == ATCS_SCAN1 && cmd_scan)) begin
                wp_r <= '0;
                rp_r <= '0;
                cnt_f_r <= '0;
            end else if (conv_end) begin
                mem_r[wp_r] <= new_res;
                wp_r <= PW'((int'(wp_r) + 1) % FIFO_DEPTH);
                if (fifo_full || fifo_pop) begin
                    rp_r <= PW'((int'(rp_r) + 1) % FIFO_DEPTH);
                end
                if (!fifo_full && !fifo_pop) begin
                    cnt_f_r <= cnt_f_r + 1'b1;
                end
            end else if (fifo_pop) begin
                rp_r <= PW'((int'(rp_r) + 1) % FIFO_DEPTH);
                cnt_f_r <= cnt_f_r - 1'b1;
            end
        end
    end

    // One-cycle interrupt pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_r <= 1'b0;
        end else if (ce) begin
            int_r <= conv_end & ((~fifo_on & intc_r[`ATCS_INT_EOC])
                | (fifo_on & (cnt_f_r == (PW+1)'(FIFO_DEPTH - 1))
                    & (intc_r[`ATCS_INT_FULL] | (mode == ATCS_SCANN & intc_r[`ATCS_INT_SCAN]))));
        end
    end

endmodule : atcs_dev

`default_nettype wire

//--- atcs_cfg.svh
`ifndef ATCS_CFG_SVH
`define ATCS_CFG_SVH

// Device register addresses carried in a write frame
`define ATCS_ADDR_CCR0 7'h00
`define ATCS_ADDR_SYS 7'h05
`define ATCS_ADDR_INT 7'h06
`define ATCS_ADDR_TRIG 7'h08
`define ATCS_ADDR_CHSEL 7'h09

// Command opcodes carried in a command frame
`define ATCS_OP_READ 7'h00
`define ATCS_OP_SCAN 7'h01
`define ATCS_OP_STOP 7'h02

// Field positions
`define ATCS_SYS_SWSTART 0
`define ATCS_SYS_FIFO 1
`define ATCS_INT_EOC 0
`define ATCS_INT_SCAN 1
`define ATCS_INT_FULL 2
`define ATCS_FRM_CMD 15

// Reset values and last channel
`define ATCS_REG_RST 8'h00
`define ATCS_CH_RST 3'h0
`define ATCS_LAST_CH 3'h7

// Timing, counted in conversion clocks (one pclk cycle each), except the NS values in nanoseconds
`define ATCS_CLK_NS 100
`define ATCS_ACQ_CYC 8'h09
`define ATCS_CONV_CYC 8'h0E
`define ATCS_AUTO_GAP 8'h12
`define ATCS_M4_WIN_NS 10000
`define ATCS_M4_WIN_CYC (`ATCS_M4_WIN_NS / `ATCS_CLK_NS)
`define ATCS_START_GAP 8'h28

// Serial frame
`define ATCS_FRM_BITS 5'h10
`define ATCS_LAST_BIT 4'hF

// Host APB register offsets
`define ATCS_APB_CMD 12'h000
`define ATCS_APB_CONVERSION_START_PIN 12'h004
`define ATCS_APB_STATUS 12'h008
`define ATCS_APB_RXDATA 12'h00C

`endif

//--- atcs_pkg.sv
package atcs_pkg;

    // Trigger mode field codes
    typedef enum logic [2:0] {
        ATCS_IDLE = 3'b000,
        ATCS_RSV1 = 3'b001,
        ATCS_MAN = 3'b010,
        ATCS_MAN_DLY = 3'b011,
        ATCS_AUTO_DLY = 3'b100,
        ATCS_SCAN1 = 3'b101,
        ATCS_SCANN = 3'b110,
        ATCS_RSV7 = 3'b111
    } atcs_mode_t;

    // Device conversion sequence
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_ACQ = 2'b01,
        CS_CONV = 2'b10,
        CS_GAP = 2'b11
    } atcs_cstate_t;

    // Host serial frame sequence
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SETUP = 3'b001,
        HS_LOW = 3'b010,
        HS_HIGH = 3'b011,
        HS_END = 3'b100
    } atcs_hstate_t;

endpackage : atcs_pkg

//--- atcs_if.sv
`timescale 1ns/1ps
`default_nettype none

interface atcs_if;
    logic sclk; // Serial clock, host driven
    logic cs_n; // Frame select, active low
    logic mosi; // Host to device data
    logic miso; // Device to host data
    logic conversion_start_pin_n; // Conversion start pin, active low
    logic int_out; // Device interrupt pulse

    modport dev (input sclk, input cs_n, input mosi, input conversion_start_pin_n, output miso, output int_out);
    modport host (output sclk, output cs_n, output mosi, output conversion_start_pin_n, input miso, input int_out);
endinterface : atcs_if

`default_nettype wire

//--- atcs_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "atcs_cfg.svh"

module atcs_host
    import atcs_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device interrupt seen by software
    output logic dev_irq,
    // Link to the device
    atcs_if.host lnk
);

    atcs_hstate_t hs_r; // Frame sequencer
    logic [15:0] txw_r; // Outgoing frame
    logic [15:0] rxw_r; // Reply word
    logic [3:0] bit_r; // Bit index
    logic sclk_r;
    logic cs_n_r;
    logic mosi_r;
    logic conversion_start_pin_n_r;
    logic [7:0] gap_r; // Start spacing counter
    logic wr_acc;
    logic rd_acc;
    logic mapped;

    assign lnk.sclk = sclk_r;
    assign lnk.cs_n = cs_n_r;
    assign lnk.mosi = mosi_r;
    assign lnk.conversion_start_pin_n = conversion_start_pin_n_r;

    ////////////////////////////////////////////////////////////////////////
    // APB decode, zero wait states
    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite & ce;
    assign rd_acc = psel & ~pwrite;
    assign mapped = (paddr == `ATCS_APB_CMD) || (paddr == `ATCS_APB_CONVERSION_START_PIN)
        || (paddr == `ATCS_APB_STATUS) || (paddr == `ATCS_APB_RXDATA);
    assign pslverr = psel & penable & ~mapped;

    // Read data, combinational from live state
    always_comb begin
        prdata = 32'h00000000;
        if (rd_acc) begin
            unique case (paddr)
                `ATCS_APB_STATUS: prdata = {29'h00000000, dev_irq, (gap_r == 8'h00), (hs_r != HS_IDLE)};
                `ATCS_APB_RXDATA: prdata = {16'h0000, rxw_r};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // Interrupt pulse held until the status is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_irq <= 1'b0;
        end else if (ce) begin
            if (lnk.int_out) begin
                dev_irq <= 1'b1;
            end else if (psel && penable && rd_acc && paddr == `ATCS_APB_STATUS) begin
                dev_irq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start pin: one-cycle low pulse, refused until spacing elapsed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_start_pin_n_r <= 1'b1;
            gap_r <= 8'h00;
        end else if (ce) begin
            conversion_start_pin_n_r <= 1'b1;
            if (wr_acc && paddr == `ATCS_APB_CONVERSION_START_PIN && gap_r == 8'h00) begin
                conversion_start_pin_n_r <= 1'b0;
                gap_r <= `ATCS_START_GAP - 8'h01;
            end else if (gap_r != 8'h00) begin
                gap_r <= gap_r - 8'h01;
            end
        end
    end

    // Frame sequencer; writes during a frame are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_r <= HS_IDLE;
            txw_r <= 16'h0000;
            rxw_r <= 16'h0000;
            bit_r <= 4'h0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            mosi_r <= 1'b0;
        end else if (ce) begin
            unique case (hs_r)
                HS_IDLE: begin
                    if (wr_acc && paddr == `ATCS_APB_CMD) begin
                        txw_r <= pwdata[15:0];
                        mosi_r <= pwdata[15];
                        cs_n_r <= 1'b0;
                        bit_r <= 4'h0;
                        hs_r <= HS_SETUP;
                    end
                end
                HS_SETUP: hs_r <= HS_LOW;
                HS_LOW: begin
                    sclk_r <= 1'b1;
                    rxw_r <= {rxw_r[14:0], lnk.miso};
                    hs_r <= HS_HIGH;
                end
                HS_HIGH: begin
                    sclk_r <= 1'b0;
                    if (bit_r == `ATCS_LAST_BIT) begin
                        hs_r <= HS_END;
                    end else begin
                        bit_r <= bit_r + 4'h1;
                        mosi_r <= txw_r[4'hE - bit_r];
                        hs_r <= HS_LOW;
                    end
                end
                HS_END: begin
                    cs_n_r <= 1'b1;
                    hs_r <= HS_IDLE;
                end
                default: hs_r <= HS_IDLE;
            endcase
        end
    end

endmodule : atcs_host

`default_nettype wire

//--- atcs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module atcs_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link and device state
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic conversion_start_pin_n,
    input wire logic int_out,
    input wire logic conv_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] gap_r; // Cycles since last start
    logic [7:0] low_r; // Cycles of frame low

    ////////////////////////////////////////////////////////////
    // Start spacing counter, saturates so idle never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_r <= 8'hFF;
        else if (!conversion_start_pin_n) gap_r <= 8'h00;
        else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end

    // Frame length counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_r <= 8'h00;
        else low_r <= cs_n ? 8'h00 : low_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////
    a_start_pulse: assert property ($fell(conversion_start_pin_n) |=> conversion_start_pin_n) else $error("start pulse too long");
    a_start_gap: assert property ($fell(conversion_start_pin_n) |-> gap_r > 8'h26) else $error("starts too close");
    a_conv_len: assert property ($rose(conv_busy) |=> conv_busy[*8] ##1 conv_busy[*5] ##1 !conv_busy)
        else $error("conversion length wrong");
    a_acq_min: assert property ($fell(conv_busy) |-> !conv_busy[*8]) else $error("acquisition too short");
    a_int_pulse: assert property (int_out |=> !int_out) else $error("interrupt pulse too long");
    a_frame_len: assert property ($rose(cs_n) |-> low_r == 8'h22) else $error("frame length wrong");
    a_sclk_frame: assert property (sclk |-> !cs_n) else $error("serial clock outside frame");
    a_sclk_pulse: assert property ($rose(sclk) |=> !sclk) else $error("serial clock pulse too long");
    a_mosi_hold: assert property ($rose(sclk) |-> $stable(mosi)) else $error("data moved at clock");

    // Main scenarios
    c_conv: cover property ($fell(conv_busy));
    c_int: cover property (int_out);
    c_frame: cover property ($rose(cs_n));
endmodule : atcs_sva

`default_nettype wire

//--- atcs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "atcs_cfg.svh"

module atcs_bench import atcs_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dev_irq, conv_busy, fifo_on, err;
    logic [11:0] paddr, last_result;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] mux_ch, c;
    logic [2:0] exp_q[$]; // Expected channel of each result
    int fails, compares;

    atcs_if lnk();
    atcs_host u_atcs_host (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dev_irq, .lnk(lnk));
    atcs_dev u_atcs_dev (.pclk, .presetn, .ce(1'b1), .lnk(lnk), .mux_ch, .conv_busy, .fifo_on, .last_result);
    atcs_sva u_atcs_sva (.pclk, .presetn, .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
        .conversion_start_pin_n(lnk.conversion_start_pin_n), .int_out(lnk.int_out), .conv_busy);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Poll a status bit, bounded
    task automatic poll(input int b, input logic v);
        for (int n = 0; n < 400; n++) begin
            apb(1'b0, `ATCS_APB_STATUS, 32'h0);
            if (rd[b] === v) return;
        end
        fails++;
        print_verdict();
    endtask : poll

    task automatic frame(input logic [15:0] w);
        poll(0, 1'b0);
        apb(1'b1, `ATCS_APB_CMD, {16'h0000, w});
        poll(0, 1'b0);
        repeat (2) @(posedge pclk);
    endtask : frame

    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        frame({1'b0, a, d});
    endtask : wreg

    task automatic start();
        poll(1, 1'b1);
        apb(1'b1, `ATCS_APB_CONVERSION_START_PIN, 32'h0);
    endtask : start

    // Wait one conversion, compare its channel with the model
    task automatic conv();
        int n;
        for (n = 0; n < 300 && conv_busy !== 1'b1; n++) @(posedge pclk);
        for (n = n; n < 300 && conv_busy !== 1'b0; n++) @(posedge pclk);
        if (n >= 300) begin
            fails++;
            print_verdict();
        end
        @(posedge pclk);
        chk(last_result[11:9], exp_q.pop_front());
    endtask : conv

    // No conversion may start for a while
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (80) begin
            @(posedge pclk);
            if (conv_busy !== 1'b0) seen = 1'b1;
        end
        chk(seen, 1'b0);
    endtask : quiet

    // Delay lands the frame in the auto gap, so no conversion is cut
    task automatic halt(input int dly, input logic [15:0] w);
        repeat (dly) @(posedge pclk);
        frame(w);
        quiet();
    endtask : halt

    ////////////////////////////////////////////////////////////
    initial begin
        atcs_mode_t idl[3];
        idl = '{ATCS_IDLE, ATCS_RSV1, ATCS_RSV7};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fails = 0;
        compares = 0;
        void'($urandom(32'h488CE1B1));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({fifo_on, mux_ch}, 4'h0);
        wreg(`ATCS_ADDR_SYS, 8'h02);
        chk(fifo_on, 1'b1);
        wreg(`ATCS_ADDR_SYS, 8'h00);
        chk(fifo_on, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h00000000, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        foreach (idl[i]) begin
            wreg(`ATCS_ADDR_TRIG, {5'h00, idl[i]});
            start();
            quiet();
        end
        // Manual channels in any order
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_MAN});
        repeat (4) begin
            c = 3'($urandom_range(7));
            wreg(`ATCS_ADDR_CHSEL, {5'h00, c});
            exp_q.push_back(c);
            start();
            conv();
        end
        wreg(`ATCS_ADDR_SYS, 8'h01);
        wreg(`ATCS_ADDR_CHSEL, 8'h03);
        exp_q.push_back(3'h3);
        wreg(`ATCS_ADDR_INT, 8'h01);
        frame({1'b1, `ATCS_OP_READ, 8'h00});
        conv();
        apb(1'b0, `ATCS_APB_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        wreg(`ATCS_ADDR_INT, 8'h00);
        wreg(`ATCS_ADDR_SYS, 8'h00);
        // Delay mux, proper order then late order
        wreg(`ATCS_ADDR_CHSEL, 8'h01);
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_MAN_DLY});
        wreg(`ATCS_ADDR_CHSEL, 8'h05);
        exp_q = '{3'h1, 3'h5, 3'h2, 3'h2, 3'h6};
        start();
        conv();
        chk(mux_ch, 3'h5);
        start();
        conv();
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_MAN});
        wreg(`ATCS_ADDR_CHSEL, 8'h02);
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_MAN_DLY});
        start();
        conv();
        wreg(`ATCS_ADDR_CHSEL, 8'h06);
        repeat (2) begin
            start();
            conv();
        end
        // Auto trigger with manual channel
        wreg(`ATCS_ADDR_CHSEL, 8'h03);
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_AUTO_DLY});
        wreg(`ATCS_ADDR_CHSEL, 8'h04);
        exp_q = '{3'h3, 3'h4, 3'h4};
        repeat (3) conv();
        halt(12, {1'b0, `ATCS_ADDR_TRIG, 8'h00});
        // Multi-scan with FIFO and scan interrupt
        wreg(`ATCS_ADDR_INT, 8'h02);
        wreg(`ATCS_ADDR_SYS, 8'h02);
        wreg(`ATCS_ADDR_CHSEL, 8'h04);
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_SCANN});
        frame({1'b1, `ATCS_OP_SCAN, 8'h00});
        exp_q = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5, 3'h6, 3'h7};
        repeat (8) conv();
        repeat (3) @(posedge pclk);
        apb(1'b0, `ATCS_APB_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        // Stop frame opens after a ninth result overwrote the oldest entry
        halt(42, {1'b1, `ATCS_OP_STOP, 8'h00});
        apb(1'b0, `ATCS_APB_RXDATA, 32'h0);
        chk(rd[15:13], 3'h5);
        // Single scan twice, FIFO refilled by the new scan
        wreg(`ATCS_ADDR_CHSEL, 8'h05);
        wreg(`ATCS_ADDR_TRIG, {5'h00, ATCS_SCAN1});
        repeat (2) begin
            frame({1'b1, `ATCS_OP_SCAN, 8'h00});
            exp_q = '{3'h5, 3'h6, 3'h7};
            repeat (3) conv();
            quiet();
        end
        for (int i = 5; i < 7; i++) begin
            frame({1'b1, `ATCS_OP_READ, 8'h00});
            apb(1'b0, `ATCS_APB_RXDATA, 32'h0);
            chk({rd[15:13], rd[3:0]}, {3'(i), 4'h0});
        end
        print_verdict();
    end
endmodule : atcs_bench

`default_nettype wire
